// ===== audio_clk_pkg.sv
// Constants shared by the audio clock divider block.
// Assumes a single 25 MHz reference clock and a 16-bit register port.
package audio_clk_pkg;
  localparam logic [31:0] PCM_DIV_ADDR  = 32'h50001c40;
  localparam logic [31:0] PCM_FRAC_ADDR = 32'h50001c42;
  localparam logic [31:0] PDM_DIVIDER_VALUE_ADDR  = 32'h50001c44;
  localparam logic [31:0] RATE_DIV_ADDR = 32'h50001c46;
  localparam logic [31:0] STATUS_ADDR   = 32'h50001c48;
  localparam int PCM_EN_BIT     = 12;
  localparam int PDM_EN_BIT     = 8;
  localparam int PDM_LEADER_BIT = 9;
  localparam int RATE_EN_BIT    = 8;
  localparam logic [13:0] PCM_DIV_RESET  = 14'h0000;
  localparam logic [15:0] PCM_FRAC_RESET = 16'h0000;
  localparam logic [9:0]  PDM_DIVIDER_VALUE_RESET  = 10'h000;
  localparam logic [8:0]  RATE_DIV_RESET = 9'h000;
  // Smallest period a flip-flop output can form from the reference clock.
  localparam logic [12:0] MIN_PERIOD = 13'h0002;
  localparam logic [12:0] CNT_RESET  = 13'h0000;
endpackage

// ===== audio_clock_dividers.sv
// Three programmable audio clock dividers with a register port.
// Assumes registers are written and read on ref_clk by a local master.
`timescale 1ns/10ps
module audio_clock_dividers #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  // Generated clocks
  output logic                   pcm_clk,
  output logic                   pdm_clk,
  output logic                   rate_conv_clk,
  // PDM clock pin
  input  wire logic              pdm_clk_pin_in,
  output logic                   pdm_clk_pin_out,
  output logic                   pdm_clk_pin_oe
);
  import audio_clk_pkg::*;

  if (ADDR_W < 32) begin : g_chk
    $error("ADDR_W must hold the full register addresses");
  end

  // Register selection, shared by the write and the read path so that both
  // always agree on which address means which register.
  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_PCM_DIV  = 3'b001,
    SEL_PCM_FRAC = 3'b010,
    SEL_PDM_DIVIDER_VALUE  = 3'b011,
    SEL_RATE_DIV = 3'b100,
    SEL_STATUS   = 3'b101
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [31:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == PCM_DIV_ADDR) begin
      sel = SEL_PCM_DIV;
    end else if (addr == PCM_FRAC_ADDR) begin
      sel = SEL_PCM_FRAC;
    end else if (addr == PDM_DIVIDER_VALUE_ADDR) begin
      sel = SEL_PDM_DIVIDER_VALUE;
    end else if (addr == RATE_DIV_ADDR) begin
      sel = SEL_RATE_DIV;
    end else if (addr == STATUS_ADDR) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction

  reg_sel_t    addr_sel;

  logic [13:0] pcm_clock_divider;
  logic [15:0] pcm_frac_pattern;
  logic [9:0]  pdm_clock_divider;
  logic [8:0]  rate_converter_clock_divider;
  logic [12:0] pcm_cnt;
  logic [12:0] pdm_cnt;
  logic [12:0] rate_cnt;
  logic [3:0]  frac_idx;
  logic        pdm_sync1;
  logic        pdm_sync2;
  logic        pdm_gen;
  logic        pcm_en;
  logic        pdm_clk_gen_on;
  logic        pdm_leader_select;
  logic        rate_conv_clk_gen_on;
  logic [7:0]  pdm_divider_value;
  logic [7:0]  rate_conv_divider;
  logic [3:0]  frac_top;
  logic        frac_corr;
  logic [12:0] pcm_period;
  logic [12:0] pdm_period;
  logic [12:0] rate_period;

  function automatic logic [3:0] top_bit(input logic [15:0] pat);
    logic [3:0] pos;
    pos = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (pat[i]) begin
        pos = 4'(i);
      end
    end
    return pos;
  endfunction

  function automatic logic [12:0] eff_period(input logic [12:0] div);
    return (div < MIN_PERIOD) ? MIN_PERIOD : div;
  endfunction

  function automatic logic [12:0] next_cnt(input logic [12:0] cnt,
                                           input logic [12:0] period);
    return (cnt >= period - 13'h0001) ? CNT_RESET : cnt + 13'h0001;
  endfunction

  function automatic logic phase_high(input logic [12:0] cnt,
                                      input logic [12:0] period);
    return cnt < (period - (period >> 1));
  endfunction

  // Upper address bits beyond the map are ignored when ADDR_W exceeds 32.
  assign addr_sel             = decode(reg_addr[31:0]);
  assign pcm_en               = pcm_clock_divider[PCM_EN_BIT];
  assign pdm_clk_gen_on       = pdm_clock_divider[PDM_EN_BIT];
  assign pdm_leader_select    = pdm_clock_divider[PDM_LEADER_BIT];
  assign rate_conv_clk_gen_on = rate_converter_clock_divider[RATE_EN_BIT];
  assign pdm_divider_value    = pdm_clock_divider[7:0];
  assign rate_conv_divider    = rate_converter_clock_divider[7:0];

  assign frac_top  = top_bit(pcm_frac_pattern);
  assign frac_corr = pcm_frac_pattern[frac_idx];
  assign pcm_period = eff_period({1'b0, pcm_clock_divider[11:0]})
                      + {12'h000, frac_corr};
  assign pdm_period  = eff_period({5'h00, pdm_divider_value});
  assign rate_period = eff_period({5'h00, rate_conv_divider});

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pcm_clock_divider <= PCM_DIV_RESET;
    end else if (reg_wr && addr_sel == SEL_PCM_DIV) begin
      pcm_clock_divider <= reg_wdata[13:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pcm_frac_pattern <= PCM_FRAC_RESET;
    end else if (reg_wr && addr_sel == SEL_PCM_FRAC) begin
      pcm_frac_pattern <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pdm_clock_divider <= PDM_DIVIDER_VALUE_RESET;
    end else if (reg_wr && addr_sel == SEL_PDM_DIVIDER_VALUE) begin
      pdm_clock_divider <= reg_wdata[9:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rate_converter_clock_divider <= RATE_DIV_RESET;
    end else if (reg_wr && addr_sel == SEL_RATE_DIV) begin
      rate_converter_clock_divider <= reg_wdata[8:0];
    end
  end

  // Read data stands only in the cycle after reg_rd is high and is zero otherwise, so a master
  // that samples late sees zero rather than a stale word.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (addr_sel == SEL_PCM_DIV) begin
        reg_rdata <= {2'b00, pcm_clock_divider};
      end else if (addr_sel == SEL_PCM_FRAC) begin
        reg_rdata <= pcm_frac_pattern;
      end else if (addr_sel == SEL_PDM_DIVIDER_VALUE) begin
        reg_rdata <= {6'h00, pdm_clock_divider};
      end else if (addr_sel == SEL_RATE_DIV) begin
        reg_rdata <= {7'h00, rate_converter_clock_divider};
      end else if (addr_sel == SEL_STATUS) begin
        reg_rdata <= {8'h00, frac_idx, 1'b0, rate_conv_clk, pdm_clk, pcm_clk};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // PCM divider. The fraction position restarts at the top bit whenever the
  // clock is stopped, so a pattern written while it is stopped begins from its first bit.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pcm_cnt  <= CNT_RESET;
      frac_idx <= 4'h0;
      pcm_clk  <= 1'b0;
    end else if (!pcm_en) begin
      pcm_cnt  <= CNT_RESET;
      frac_idx <= frac_top;
      pcm_clk  <= 1'b0;
    end else begin
      pcm_cnt <= next_cnt(pcm_cnt, pcm_period);
      pcm_clk <= phase_high(pcm_cnt, pcm_period);
      if (pcm_cnt >= pcm_period - 13'h0001) begin
        frac_idx <= (frac_idx == 4'h0) ? frac_top : frac_idx - 4'h1;
      end
    end
  end

  // The pin is sampled twice before use; it comes from another device.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pdm_sync1 <= 1'b0;
      pdm_sync2 <= 1'b0;
    end else begin
      pdm_sync1 <= pdm_clk_pin_in;
      pdm_sync2 <= pdm_sync1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pdm_cnt <= CNT_RESET;
      pdm_gen <= 1'b0;
    end else if (!pdm_clk_gen_on) begin
      pdm_cnt <= CNT_RESET;
      pdm_gen <= 1'b0;
    end else begin
      pdm_cnt <= next_cnt(pdm_cnt, pdm_period);
      pdm_gen <= phase_high(pdm_cnt, pdm_period);
    end
  end

  // The follower path adds three cycles of delay from the pin; this is the
  // price of a safe crossing and limits the usable follower rate.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pdm_clk <= 1'b0;
    end else begin
      pdm_clk <= pdm_leader_select ? pdm_gen : pdm_sync2;
    end
  end

  // Drive value and enable share one select, so the pin never shows the
  // generated clock while the enable is still low.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pdm_clk_pin_out <= 1'b0;
    end else begin
      pdm_clk_pin_out <= pdm_leader_select & pdm_gen;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pdm_clk_pin_oe <= 1'b0;
    end else begin
      pdm_clk_pin_oe <= pdm_leader_select;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rate_cnt      <= CNT_RESET;
      rate_conv_clk <= 1'b0;
    end else if (!rate_conv_clk_gen_on) begin
      rate_cnt      <= CNT_RESET;
      rate_conv_clk <= 1'b0;
    end else begin
      rate_cnt      <= next_cnt(rate_cnt, rate_period);
      rate_conv_clk <= phase_high(rate_cnt, rate_period);
    end
  end

endmodule // audio_clock_dividers

// ===== audio_clock_dividers_bench.sv
// Self-checking bench for the audio clock dividers.
// Assumes the package and the bound checker are compiled first.
`timescale 1ns/10ps
module audio_clock_dividers_bench;
  import audio_clk_pkg::*;
  logic        ref_clk = 0;
  logic        rst_b = 0;
  logic [31:0] reg_addr = 32'h00000000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic        pin_in = 0;
  logic [15:0] reg_rdata, n;
  logic        pcm_clk, pdm_clk, rate_clk, pin_out, pin_oe, p, q;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [31:0] addrs [4] = '{PCM_DIV_ADDR, PCM_FRAC_ADDR, PDM_DIVIDER_VALUE_ADDR, RATE_DIV_ADDR};
  logic [15:0] masks [4] = '{16'h3fff, 16'hffff, 16'h03ff, 16'h01ff};
  logic [15:0] pers [9] = '{16'h6, 16'h5, 16'h5, 16'h5, 16'h6, 16'h5, 16'h5, 16'h5, 16'h5};
  audio_clock_dividers dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pcm_clk(pcm_clk), .pdm_clk(pdm_clk), .rate_conv_clk(rate_clk),
    .pdm_clk_pin_in(pin_in), .pdm_clk_pin_out(pin_out), .pdm_clk_pin_oe(pin_oe));
  always #20 ref_clk = ~ref_clk;
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The pin toggles slowly so the follower path sees real edges.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 0) pin_in <= ~pin_in;
    if (cyc == 2000) begin
      miscompares++;
      complete_run;
    end
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    cmp("register", exp, reg_rdata);
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) rd(addrs[i], 16'h0000);
    rd(32'h50001c4a, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], 16'hffff);
      rd(addrs[i], masks[i]);
      wr(addrs[i], 16'h0000);
    end
    wr(PCM_DIV_ADDR, 16'h1004);
    repeat (20) @(posedge ref_clk);
    wr(PCM_DIV_ADDR, 16'h0000);
    wr(RATE_DIV_ADDR, 16'h0103);
    n = 16'h0000;
    repeat (12) begin
      @(negedge ref_clk);
      n = n + {15'h0000, rate_clk};
    end
    @(posedge ref_clk);
    cmp("rate clock high cycles", 16'h0008, n);
    wr(RATE_DIV_ADDR, 16'h0000);
    wr(PDM_DIVIDER_VALUE_ADDR, 16'h0302);
    n = 16'h0000;
    repeat (12) begin
      @(negedge ref_clk);
      n = n + {15'h0000, pdm_clk};
    end
    @(posedge ref_clk);
    cmp("pdm leader high cycles", 16'h0006, n);
    wr(PDM_DIVIDER_VALUE_ADDR, 16'h0000);
    repeat (30) @(posedge ref_clk);
    wr(PCM_FRAC_ADDR, 16'h0110);
    wr(PCM_DIV_ADDR, 16'h1005);
    for (int k = 0; k < 20 && pcm_clk !== 1'b1; k++) @(negedge ref_clk);
    p = 1'b1;
    for (int i = 0; i < 9; i++) begin
      n = 16'h0000;
      do begin
        @(negedge ref_clk);
        n++;
        q = p;
        p = pcm_clk;
      end while (!(p === 1'b1 && q === 1'b0) && n < 16'h0020);
      cmp("pcm period", pers[i], n);
    end
    complete_run;
  end
endmodule // audio_clock_dividers_bench

// ===== audio_clock_dividers_checker.sv
// Port assertions for the audio clock dividers.
// Assumes one ref_clk domain and a bind onto the design.
`timescale 1ns/10ps
module audio_clock_dividers_checker #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  // Clocks and pin
  input wire logic              pcm_clk,
  input wire logic              pdm_clk,
  input wire logic              rate_conv_clk,
  input wire logic              pdm_clk_pin_in,
  input wire logic              pdm_clk_pin_out,
  input wire logic              pdm_clk_pin_oe
);
  import audio_clk_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic pcm_w  = reg_wr && reg_addr == PCM_DIV_ADDR;
  wire logic rate_w = reg_wr && reg_addr == RATE_DIV_ADDR;
  a_pcm_period: assert property (pcm_w && reg_wdata == 16'h1004 |-> ##2 pcm_clk[*2]
    ##1 !pcm_clk[*2] ##1 pcm_clk) else $error("pcm clock period wrong");
  a_pcm_stop: assert property (pcm_w && !reg_wdata[12] |-> ##3 !pcm_clk[*3])
    else $error("pcm clock runs while disabled");
  a_rate_period: assert property (rate_w && reg_wdata == 16'h0103 |->
    ##2 rate_conv_clk[*2] ##1 !rate_conv_clk ##1 rate_conv_clk) else $error("rate clock wrong");
  a_rate_stop: assert property (rate_w && !reg_wdata[8] |-> ##3 !rate_conv_clk[*3])
    else $error("rate clock runs while disabled");
  a_pdm_leader: assert property (reg_wr && reg_addr == PDM_DIVIDER_VALUE_ADDR && reg_wdata == 16'h0302
    |-> ##3 pdm_clk_pin_oe && pdm_clk_pin_out ##1 !pdm_clk_pin_out) else $error("pdm lead bad");
  a_follow_pin: assert property (!pdm_clk_pin_oe[*5] |-> pdm_clk == $past(pdm_clk_pin_in, 3))
    else $error("pdm follower does not track pin");
  a_follow_quiet: assert property (!pdm_clk_pin_oe |-> !pdm_clk_pin_out)
    else $error("pin driven while follower");
  a_reset_zero: assert property (!$past(rst_b) |-> !pcm_clk && !rate_conv_clk && !pdm_clk_pin_oe)
    else $error("outputs not cleared by reset");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule // audio_clock_dividers_checker
bind audio_clock_dividers audio_clock_dividers_checker #(.ADDR_W(ADDR_W)) chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pcm_clk(pcm_clk),
  .pdm_clk(pdm_clk), .rate_conv_clk(rate_conv_clk), .pdm_clk_pin_in(pdm_clk_pin_in),
  .pdm_clk_pin_out(pdm_clk_pin_out), .pdm_clk_pin_oe(pdm_clk_pin_oe));
